// ### design/frps_defines.svh
// Constants for the flag register and page store command interpreter.
`ifndef FRPS_DEFINES_SVH
`define FRPS_DEFINES_SVH

`define FRPS_STX          8'h02
`define FRPS_ETX          8'h03
`define FRPS_ACK          8'h06
`define FRPS_NAK          8'h15
`define FRPS_CH_0         8'h30
`define FRPS_CH_9         8'h39
`define FRPS_CH_A         8'h41
`define FRPS_CH_C         8'h43
`define FRPS_CH_F         8'h46
`define FRPS_CH_L         8'h4C
`define FRPS_CH_M         8'h4D
`define FRPS_CH_R         8'h52
`define FRPS_CH_W         8'h57
`define FRPS_HEX_ALPHA    8'h37
`define FRPS_NIB_TEN      4'hA
`define FRPS_PAGES        3'h6
`define FRPS_ITEMS        3'h6
`define FRPS_LAST_ITEM    3'h5
`define FRPS_MAX_LEN      3'h7
`define FRPS_LEN_SHORT    3'h3
`define FRPS_LEN_PAGE     3'h2
`define FRPS_REPLY_SHORT  4'h3
`define FRPS_REPLY_READ   4'hA
`define FRPS_CFG_MASK     16'h01FF
`define FRPS_WORD_ZERO    16'h0000
`define FRPS_FLAG_ITEM    3'h0

`endif

// ### design/frps_pkg.sv
// Types shared by the flag register and page store design.
package frps_pkg;

  typedef logic [15:0] frps_word_type;

  // Gray steps along boot, load, idle, receive, execute, respond.
  typedef enum logic [2:0] {
    ST_BOOT = 3'h0,
    ST_LOAD = 3'h1,
    ST_IDLE = 3'h3,
    ST_RECV = 3'h2,
    ST_EXEC = 3'h6,
    ST_RESP = 3'h7,
    ST_SAVE = 3'h5
  } frps_state_type;

endpackage : frps_pkg

// ### design/frps_page_mem.sv
// Page store: eight pages of eight words with a registered read port.
`timescale 1ns/1ps
`include "frps_defines.svh"

module frps_page_mem
  import frps_pkg::*;
(
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  // Access port
  input  wire logic          we_i,
  input  wire logic [5:0]    addr_i,
  input  wire frps_word_type wdata_i,
  output frps_word_type      rdata_o
);

  frps_word_type mem [0:63];
  logic [7:0]    written;
  logic [7:0]    next_written;
  frps_word_type next_rdata;

  // A page never saved reads as the factory default of all zeros.
  always_comb
  begin
    next_written = written;
    if (we_i)
    begin
      next_written[addr_i[5:3]] = 1'b1;
    end
    next_rdata = written[addr_i[5:3]] ? mem[addr_i] : `FRPS_WORD_ZERO;
  end

  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem[addr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      written <= 8'h00;
      rdata_o <= `FRPS_WORD_ZERO;
    end
    else
    begin
      written <= next_written;
      rdata_o <= next_rdata;
    end
  end

endmodule : frps_page_mem

// ### design/frps_cmd.sv
// Framed serial command interpreter for the mode flag register and program pages.
// Behaviour
// - A flag write arrives as STX, the write code, four hex characters and ETX, and gets STX ACK ETX or STX NAK ETX.
// - The four hex characters of a flag write become the new 16-bit mode flag register.
// - A flag write changes only the working copy and never touches the page store.
// - A flag read gets STX ACK, the echoed read code, the register value and ETX, or STX NAK ETX.
// - The read reply carries the register as four hex characters over the full 0000 to FFFF range.
// - The page store is written only by a page-save command naming one page letter.
// - Six pages A to F each hold flag, manual gain, auto gain, offset, shutter speed and shutter table.
// - At power-on the page named by the mode switch is copied into the working settings.
// - A setting changed on command replaces the working value at once until power-off; the code drops such changes while a page load is in progress.
// - A page-save command for A to F writes all working page items into that page.
// - A page-load arrives as STX, the load letter, a page letter A to F and ETX, and gets ACK or NAK.
// - A completed page-load puts the stored page values into the working settings.
// - Factory default flag register contents are all zeros.
// - Configuration writes leave write-inhibited bits unchanged without error, so FFFF reads back as 01FF.
`timescale 1ns/1ps
`include "frps_defines.svh"

module frps_cmd
  import frps_pkg::*;
(
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          resetn_i,
  // Receive byte stream from the host
  input  wire logic          rx_valid_i,
  input  wire logic [7:0]    rx_data_i,
  output logic               rx_ready_o,
  // Transmit byte stream to the host
  output logic               tx_valid_o,
  output logic [7:0]         tx_data_o,
  input  wire logic          tx_ready_i,
  // Mode switch page index, 0 to 5 for A to F
  input  wire logic [2:0]    mode_switch_i,
  // Working setting changes from other command handlers
  input  wire logic          item_we_i,
  input  wire logic [2:0]    item_sel_i,
  input  wire frps_word_type item_data_i,
  // Working settings
  output frps_word_type      flag_o,
  output frps_word_type      manual_gain_o,
  output frps_word_type      auto_gain_o,
  output frps_word_type      offset_o,
  output frps_word_type      shutter_o,
  output frps_word_type      shutter_table_o,
  output frps_word_type      config_o
);

  function automatic logic is_hex(input logic [7:0] c);
    is_hex = (c >= `FRPS_CH_0 && c <= `FRPS_CH_9) || (c >= `FRPS_CH_A && c <= `FRPS_CH_F);
  endfunction : is_hex

  function automatic logic [3:0] hex_val(input logic [7:0] c);
    logic [7:0] d;
    d = (c <= `FRPS_CH_9) ? c - `FRPS_CH_0 : c - `FRPS_HEX_ALPHA;
    hex_val = d[3:0];
  endfunction : hex_val

  function automatic logic [7:0] to_hex(input logic [3:0] n);
    to_hex = (n < `FRPS_NIB_TEN) ? `FRPS_CH_0 + {4'h0, n} : `FRPS_HEX_ALPHA + {4'h0, n};
  endfunction : to_hex

  logic                rst_meta;
  logic                rst_n;
  frps_state_type      state;
  frps_state_type      next_state;
  logic [6:0][7:0]     rx_q;
  logic [6:0][7:0]     next_rx_q;
  logic [2:0]          rx_len;
  logic [2:0]          next_rx_len;
  logic                ovf;
  logic                next_ovf;
  logic [9:0][7:0]     resp_q;
  logic [9:0][7:0]     next_resp_q;
  logic [3:0]          resp_cnt;
  logic [3:0]          next_resp_cnt;
  logic                next_tx_valid;
  logic                next_rx_ready;
  logic [5:0][15:0]    work_q;
  logic [5:0][15:0]    next_work_q;
  frps_word_type       cfg_q;
  frps_word_type       next_cfg_q;
  logic [2:0]          page;
  logic [2:0]          next_page;
  logic [2:0]          cnt;
  logic [2:0]          next_cnt;
  logic                reply;
  logic                next_reply;
  logic                mem_we;
  frps_word_type       mem_rdata;
  frps_word_type       rx_word;
  frps_word_type       rd_val;
  logic                hex_ok;
  logic                code_mf;
  logic                code_mc;
  logic                letter_ok;
  logic                dec_wflag;
  logic                dec_rflag;
  logic                dec_wcfg;
  logic                dec_bad;

  // Reset is released through two flops so every register leaves reset together.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  frps_page_mem u_mem (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .we_i    (mem_we),
    .addr_i  ({page, cnt}),
    .wdata_i (work_q[cnt]),
    .rdata_o (mem_rdata)
  );

  always_comb
  begin
    next_state    = state;
    next_rx_q     = rx_q;
    next_rx_len   = rx_len;
    next_ovf      = ovf;
    next_resp_q   = resp_q;
    next_resp_cnt = resp_cnt;
    next_work_q   = work_q;
    next_cfg_q    = cfg_q;
    next_page     = page;
    next_cnt      = cnt;
    next_reply    = reply;
    mem_we        = 1'b0;
    rx_word       = {hex_val(rx_q[3]), hex_val(rx_q[4]), hex_val(rx_q[5]), hex_val(rx_q[6])};
    hex_ok        = is_hex(rx_q[3]) && is_hex(rx_q[4]) && is_hex(rx_q[5]) && is_hex(rx_q[6]);
    code_mf       = rx_q[1] == `FRPS_CH_M && rx_q[2] == `FRPS_CH_F;
    code_mc       = rx_q[1] == `FRPS_CH_M && rx_q[2] == `FRPS_CH_C;
    letter_ok     = rx_q[1] >= `FRPS_CH_A && rx_q[1] <= `FRPS_CH_F;
    dec_wflag     = !ovf && rx_len == `FRPS_MAX_LEN && rx_q[0] == `FRPS_CH_W && code_mf && hex_ok;
    dec_wcfg      = !ovf && rx_len == `FRPS_MAX_LEN && rx_q[0] == `FRPS_CH_W && code_mc && hex_ok;
    dec_rflag     = !ovf && rx_len == `FRPS_LEN_SHORT && rx_q[0] == `FRPS_CH_R && (code_mf || code_mc);
    dec_bad       = !(dec_wflag || dec_wcfg || dec_rflag || (!ovf && rx_len == `FRPS_LEN_PAGE
                    && letter_ok && (rx_q[0] == `FRPS_CH_W || rx_q[0] == `FRPS_CH_L)));
    rd_val        = code_mf ? work_q[`FRPS_FLAG_ITEM] : cfg_q;
    if (tx_valid_o && tx_ready_i)
    begin
      next_resp_q   = resp_q >> 8;
      next_resp_cnt = resp_cnt - 4'h1;
    end
    // Other handlers change settings at once; a page load in progress takes priority.
    if (item_we_i && state != ST_LOAD && item_sel_i < `FRPS_ITEMS)
    begin
      next_work_q[item_sel_i] = item_data_i;
    end
    case (state)
      ST_BOOT:
      begin
        next_page  = (mode_switch_i < `FRPS_PAGES) ? mode_switch_i : 3'h0;
        next_cnt   = 3'h0;
        next_reply = 1'b0;
        next_state = ST_LOAD;
      end
      ST_LOAD:
      begin
        // Read data lags the address by one cycle, so word cnt-1 lands now.
        if (cnt != 3'h0)
        begin
          next_work_q[cnt - 3'h1] = mem_rdata;
        end
        if (cnt == `FRPS_ITEMS)
        begin
          next_state = reply ? ST_RESP : ST_IDLE;
          if (reply)
          begin
            next_resp_q   = {56'h0, `FRPS_ETX, `FRPS_ACK, `FRPS_STX};
            next_resp_cnt = `FRPS_REPLY_SHORT;
          end
        end
        else
        begin
          next_cnt = cnt + 3'h1;
        end
      end
      ST_IDLE:
      begin
        if (rx_valid_i && rx_data_i == `FRPS_STX)
        begin
          next_rx_len = 3'h0;
          next_ovf    = 1'b0;
          next_state  = ST_RECV;
        end
      end
      ST_RECV:
      begin
        if (rx_valid_i)
        begin
          if (rx_data_i == `FRPS_ETX)
          begin
            next_state = ST_EXEC;
          end
          else if (rx_data_i == `FRPS_STX)
          begin
            next_rx_len = 3'h0;
            next_ovf    = 1'b0;
          end
          else if (rx_len == `FRPS_MAX_LEN)
          begin
            next_ovf = 1'b1;
          end
          else
          begin
            next_rx_q[rx_len] = rx_data_i;
            next_rx_len       = rx_len + 3'h1;
          end
        end
      end
      ST_EXEC:
      begin
        next_state    = ST_RESP;
        next_resp_q   = {56'h0, `FRPS_ETX, `FRPS_ACK, `FRPS_STX};
        next_resp_cnt = `FRPS_REPLY_SHORT;
        next_cnt      = 3'h0;
        // Only the low three bits of the letter offset are kept; A..F map to 0..5.
        next_page     = 3'(rx_q[1] - `FRPS_CH_A);
        if (dec_bad)
        begin
          next_resp_q[1] = `FRPS_NAK;
        end
        else if (dec_wflag)
        begin
          next_work_q[`FRPS_FLAG_ITEM] = rx_word;
        end
        else if (dec_wcfg)
        begin
          next_cfg_q = (cfg_q & ~`FRPS_CFG_MASK) | (rx_word & `FRPS_CFG_MASK);
        end
        else if (dec_rflag)
        begin
          next_resp_q   = {`FRPS_ETX, to_hex(rd_val[3:0]), to_hex(rd_val[7:4]),
                           to_hex(rd_val[11:8]), to_hex(rd_val[15:12]),
                           rx_q[2], rx_q[1], rx_q[0], `FRPS_ACK, `FRPS_STX};
          next_resp_cnt = `FRPS_REPLY_READ;
        end
        else if (rx_q[0] == `FRPS_CH_W)
        begin
          next_state    = ST_SAVE;
          next_resp_cnt = 4'h0;
        end
        else
        begin
          next_reply    = 1'b1;
          next_state    = ST_LOAD;
          next_resp_cnt = 4'h0;
        end
      end
      ST_SAVE:
      begin
        mem_we = 1'b1;
        if (cnt == `FRPS_LAST_ITEM)
        begin
          next_state    = ST_RESP;
          next_resp_q   = {56'h0, `FRPS_ETX, `FRPS_ACK, `FRPS_STX};
          next_resp_cnt = `FRPS_REPLY_SHORT;
        end
        else
        begin
          next_cnt = cnt + 3'h1;
        end
      end
      ST_RESP:
      begin
        if (resp_cnt == 4'h0)
        begin
          next_state = ST_IDLE;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
      end
    endcase
    next_tx_valid = next_resp_cnt != 4'h0;
    next_rx_ready = next_state == ST_IDLE || next_state == ST_RECV;
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state      <= ST_BOOT;
      rx_q       <= '0;
      rx_len     <= 3'h0;
      ovf        <= 1'b0;
      resp_q     <= '0;
      resp_cnt   <= 4'h0;
      tx_valid_o <= 1'b0;
      rx_ready_o <= 1'b0;
      work_q     <= '0;
      cfg_q      <= `FRPS_WORD_ZERO;
      page       <= 3'h0;
      cnt        <= 3'h0;
      reply      <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      rx_q       <= next_rx_q;
      rx_len     <= next_rx_len;
      ovf        <= next_ovf;
      resp_q     <= next_resp_q;
      resp_cnt   <= next_resp_cnt;
      tx_valid_o <= next_tx_valid;
      rx_ready_o <= next_rx_ready;
      work_q     <= next_work_q;
      cfg_q      <= next_cfg_q;
      page       <= next_page;
      cnt        <= next_cnt;
      reply      <= next_reply;
    end
  end

  assign tx_data_o       = resp_q[0];
  assign flag_o          = work_q[0];
  assign manual_gain_o   = work_q[1];
  assign auto_gain_o     = work_q[2];
  assign offset_o        = work_q[3];
  assign shutter_o       = work_q[4];
  assign shutter_table_o = work_q[5];
  assign config_o        = cfg_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  a_reply_opens_stx: assert property ($rose(tx_valid_o) |-> tx_data_o == `FRPS_STX)
    else $error("Reply does not open with STX.");
  a_flag_write_value: assert property (state == ST_EXEC && dec_wflag |=>
    flag_o == $past(rx_word) && tx_valid_o && resp_q[1] == `FRPS_ACK)
    else $error("Flag write did not load the value with ACK.");
  a_flag_write_volatile: assert property (state == ST_EXEC && dec_wflag |=> !mem_we [*2])
    else $error("Store written right after a command decode.");
  a_read_reply_len: assert property (state == ST_EXEC && dec_rflag |=>
    resp_cnt == `FRPS_REPLY_READ && resp_q[9] == `FRPS_ETX)
    else $error("Read reply has wrong length or ending.");
  a_read_hex_digit: assert property (state == ST_EXEC && dec_rflag && code_mf |=>
    resp_q[5] == to_hex($past(work_q[0][15:12])))
    else $error("Read reply leading digit wrong.");
  a_store_only_save: assert property (mem_we |-> state == ST_SAVE)
    else $error("Page store written outside a save.");
  a_boot_page_pick: assert property (state == ST_BOOT |=>
    state == ST_LOAD && (page == $past(mode_switch_i) || $past(mode_switch_i) >= `FRPS_PAGES))
    else $error("Boot did not select the mode switch page.");
  a_load_applies_flag: assert property (state == ST_LOAD && cnt == 3'h1 |=>
    flag_o == $past(mem_rdata))
    else $error("Loaded flag word not applied.");
  a_save_six_words: assert property (state == ST_EXEC && !dec_bad && !dec_wflag && !dec_wcfg
    && !dec_rflag && rx_q[0] == `FRPS_CH_W |=> mem_we [*6] ##1 !mem_we)
    else $error("Save did not write six words.");
  a_cfg_inhibit_bits: assert property (state == ST_EXEC && dec_wcfg |=>
    (cfg_q & ~`FRPS_CFG_MASK) == ($past(cfg_q) & ~`FRPS_CFG_MASK))
    else $error("Inhibited configuration bits changed.");
  a_nak_keeps_state: assert property (state == ST_EXEC && dec_bad && !item_we_i |=>
    work_q == $past(work_q) && cfg_q == $past(cfg_q) && resp_q[1] == `FRPS_NAK)
    else $error("Rejected command changed state or missed NAK.");

endmodule : frps_cmd

// ### verification/frps_host.sv
// Host model that frames commands into the interpreter and collects its replies.
`timescale 1ns/1ps

module frps_host
(
  // Clock
  input  wire logic       clk_i,
  // Bytes toward the interpreter
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o,
  input  wire logic       rx_ready_i,
  // Bytes from the interpreter
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_ready_o
);
  logic [7:0] stall;
  logic       sending;

  initial
  begin
    rx_valid_o = 1'b0;
    rx_data_o  = 8'h00;
    tx_ready_o = 1'b0;
    stall      = 8'h5A;
    sending    = 1'b0;
  end

  // Reply bytes see irregular back-pressure; an idle data line never holds a stale byte.
  always @(posedge clk_i)
  begin
    stall      <= {stall[6:0], stall[7] ^ stall[5]};
    tx_ready_o <= stall[0] | stall[3];
    if (!sending)
      rx_data_o <= ~rx_data_o;
  end

  // Each byte is held until an edge samples ready high, then the next one follows.
  task automatic send(input logic [7:0] frame[$]);
    int n;
    // Raised before the edge so the idle toggling never drives the data line in the same step.
    sending = 1'b1;
    @(posedge clk_i);
    foreach (frame[i])
    begin
      rx_valid_o <= 1'b1;
      rx_data_o  <= frame[i];
      n = 0;
      do
      begin
        @(posedge clk_i);
        n++;
      end
      while (rx_ready_i !== 1'b1 && n < 400);
    end
    rx_valid_o <= 1'b0;
    sending = 1'b0;
  endtask : send

  task automatic get(output logic [7:0] reply[$], input int count);
    int n;
    reply = {};
    n = 0;
    while (reply.size() < count && n < 400)
    begin
      @(posedge clk_i);
      n++;
      if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1)
        reply.push_back(tx_data_i);
    end
  endtask : get
endmodule : frps_host

// ### verification/frps_cmd_tb.sv
// Self-checking bench for the flag register and page store command interpreter.
`timescale 1ns/1ps
`include "frps_defines.svh"

module frps_cmd_tb
  import frps_pkg::*;
;
  typedef logic [7:0] frps_bytes_type [$];

  logic          clk_i = 1'b0;
  logic          resetn_i;
  logic          rx_valid_i;
  logic [7:0]    rx_data_i;
  logic          rx_ready_o;
  logic          tx_valid_o;
  logic [7:0]    tx_data_o;
  logic          tx_ready_i;
  logic [2:0]    mode_switch_i;
  logic          item_we_i;
  logic [2:0]    item_sel_i;
  frps_word_type item_data_i;
  frps_word_type cur [0:5];
  frps_word_type mdl [0:5];
  frps_word_type pg  [0:5][0:5];
  frps_word_type config_o;
  frps_bytes_type ack;
  frps_bytes_type nak;
  frps_bytes_type body;
  frps_word_type  v;
  logic [2:0]     p;
  int            seed;
  int            miscompares;
  int            samples_checked;
  int            cycles;

  always #12.5 clk_i = ~clk_i;

  frps_cmd i_dut (
    .clk_i           (clk_i),
    .resetn_i        (resetn_i),
    .rx_valid_i      (rx_valid_i),
    .rx_data_i       (rx_data_i),
    .rx_ready_o      (rx_ready_o),
    .tx_valid_o      (tx_valid_o),
    .tx_data_o       (tx_data_o),
    .tx_ready_i      (tx_ready_i),
    .mode_switch_i   (mode_switch_i),
    .item_we_i       (item_we_i),
    .item_sel_i      (item_sel_i),
    .item_data_i     (item_data_i),
    .flag_o          (cur[0]),
    .manual_gain_o   (cur[1]),
    .auto_gain_o     (cur[2]),
    .offset_o        (cur[3]),
    .shutter_o       (cur[4]),
    .shutter_table_o (cur[5]),
    .config_o        (config_o)
  );

  frps_host i_host (
    .clk_i      (clk_i),
    .rx_valid_o (rx_valid_i),
    .rx_data_o  (rx_data_i),
    .rx_ready_i (rx_ready_o),
    .tx_valid_i (tx_valid_o),
    .tx_data_i  (tx_data_o),
    .tx_ready_o (tx_ready_i)
  );

  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction : hexc

  function automatic frps_bytes_type hex4(input frps_word_type w);
    return {hexc(w[15:12]), hexc(w[11:8]), hexc(w[7:4]), hexc(w[3:0])};
  endfunction : hex4

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  task automatic check_word(input string what, input frps_word_type e, input frps_word_type g);
    samples_checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : check_word

  task automatic check_reply(input frps_bytes_type e, input frps_bytes_type g);
    samples_checked++;
    if (g.size() != e.size())
    begin
      miscompares++;
      $display("[ERR] reply length expected %0d seen %0d", e.size(), g.size());
    end
    else
      foreach (e[i])
        if (g[i] !== e[i])
        begin
          miscompares++;
          $display("[ERR] reply byte %0d expected %h seen %h", i, e[i], g[i]);
        end
  endtask : check_reply

  task automatic check_all();
    repeat (2) @(posedge clk_i);
    for (int k = 0; k < 6; k++)
      check_word($sformatf("setting %0d", k), mdl[k], cur[k]);
  endtask : check_all

  task automatic cmd(input frps_bytes_type b, input frps_bytes_type e);
    frps_bytes_type f;
    frps_bytes_type g;
    f = {`FRPS_STX, b, `FRPS_ETX};
    i_host.send(f);
    i_host.get(g, e.size());
    check_reply(e, g);
  endtask : cmd

  task automatic set_item(input logic [2:0] sel, input frps_word_type val);
    @(posedge clk_i);
    item_we_i   <= 1'b1;
    item_sel_i  <= sel;
    item_data_i <= val;
    @(posedge clk_i);
    item_we_i   <= 1'b0;
    mdl[sel] = val;
  endtask : set_item

  // A hang anywhere ends the run as a failure instead of stalling the simulator.
  initial cycles = 0;
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  initial
  begin
    seed = 60;
    miscompares = 0;
    samples_checked = 0;
    ack = {`FRPS_STX, `FRPS_ACK, `FRPS_ETX};
    nak = {`FRPS_STX, `FRPS_NAK, `FRPS_ETX};
    foreach (pg[i, k])
      pg[i][k] = 16'h0000;
    foreach (mdl[k])
      mdl[k] = 16'h0000;
    resetn_i = 1'b0;
    item_we_i = 1'b0;
    item_sel_i = 3'h0;
    item_data_i = 16'h0000;
    mode_switch_i = 3'($unsigned($random(seed)) % 6);
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    check_all();
    for (int i = 0; i < 8; i++)
    begin
      v = (i == 0) ? 16'h0000 : (i == 1) ? 16'hFFFF : frps_word_type'($random(seed));
      cmd({`FRPS_CH_W, `FRPS_CH_M, `FRPS_CH_F, hex4(v)}, ack);
      mdl[0] = v;
      check_all();
      cmd({`FRPS_CH_R, `FRPS_CH_M, `FRPS_CH_F},
          {`FRPS_STX, `FRPS_ACK, `FRPS_CH_R, `FRPS_CH_M, `FRPS_CH_F, hex4(v), `FRPS_ETX});
    end
    for (int r = 0; r < 4; r++)
    begin
      p = 3'($unsigned($random(seed)) % 6);
      for (int k = 0; k < 6; k++)
        set_item(3'(k), frps_word_type'($random(seed)));
      check_all();
      cmd({`FRPS_CH_W, `FRPS_CH_A + {5'h00, p}}, ack);
      pg[p] = mdl;
      v = frps_word_type'($random(seed));
      cmd({`FRPS_CH_W, `FRPS_CH_M, `FRPS_CH_F, hex4(v)}, ack);
      set_item(3'h3, frps_word_type'($random(seed)));
      p = (r == 3) ? 3'h5 : p;
      cmd({`FRPS_CH_L, `FRPS_CH_A + {5'h00, p}}, ack);
      mdl = pg[p];
      check_all();
    end
    for (int i = 0; i < 5; i++)
    begin
      case (i)
        0: body = {`FRPS_CH_W, `FRPS_CH_M, `FRPS_CH_F, `FRPS_CH_0, `FRPS_CH_0, 8'h61, 8'h31};
        1: body = {`FRPS_CH_W, `FRPS_CH_M, 8'h58, `FRPS_CH_0, `FRPS_CH_0, `FRPS_CH_0, 8'h31};
        2: body = {`FRPS_CH_L, 8'h47};
        3: body = {`FRPS_CH_W, 8'h47};
        default: body = {`FRPS_CH_R, `FRPS_CH_M, `FRPS_CH_F, `FRPS_CH_0};
      endcase
      cmd(body, nak);
      check_all();
    end
    cmd({`FRPS_CH_W, `FRPS_CH_M, `FRPS_CH_C, hex4(16'hFFFF)}, ack);
    check_word("config", 16'h01FF, config_o);
    cmd({`FRPS_CH_R, `FRPS_CH_M, `FRPS_CH_C},
        {`FRPS_STX, `FRPS_ACK, `FRPS_CH_R, `FRPS_CH_M, `FRPS_CH_C, hex4(16'h01FF), `FRPS_ETX});
    check_all();
    end_of_test();
  end
endmodule : frps_cmd_tb
